//--- tsc_top.sv
// Tape sender control sequencer with APB setup port
//
// The APB register port and the address map were left to the implementer.
module tsc_top import tsc_pkg::*; #(
  parameter int NSUP = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operator panel
  input wire tsc_sw_t sw_in,
  input wire logic [7:0] header_char_select,
  output tsc_lamp_t lamp,
  // Master reader
  input wire logic tape_in,
  input wire logic feed_in,
  input wire logic [7:0] read_bits,
  input wire logic [7:0] verify_bits,
  output logic motor_on,
  output logic alarm_contact,
  // Supplementary transmitters
  input wire logic [NSUP-1:0] supp_bid,
  input wire logic [NSUP*8-1:0] supp_data,
  // Per reader, bit 0 is the master
  output logic [NSUP:0] reader_step,
  output logic [NSUP:0] online,
  output logic [NSUP:0] prio_lamp,
  // Serial link and priority line
  input wire logic link_clk,
  input wire logic prio_in_b,
  output logic serial_out
);
  // Owner index width
  localparam int OW = $clog2(NSUP + 1);
  // Width of all pin inputs taken together
  localparam int PW = 36 + NSUP * 9;
  // Pin levels loaded at reset; the priority line idles high, so a zero here
  // would flash every priority lamp just after reset
  localparam logic [PW-1:0] PIN_IDLE = PW'(1) << (NSUP * 9 + 24);

  // Reset release chain
  logic rst_m_b_q;
  logic rst_s_b_q;
  // Pin synchroniser stages
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_m_q;
  logic [PW-1:0] pin_s_q;
  // Synchronised pins
  tsc_sw_t sw_s;
  logic tape_s;
  logic feed_s;
  logic lclk_s;
  logic prio_s_b;
  logic [7:0] rd_s;
  logic [7:0] vf_s;
  logic [7:0] hsel_s;
  logic [NSUP-1:0] sbid_s;
  logic [NSUP*8-1:0] sdata_s;
  // Previous samples for edge finding
  tsc_sw_t sw_p_q;
  logic feed_p_q;
  logic lclk_p_q;
  // Switch edges
  tsc_sw_t press;
  tsc_sw_t rel;
  logic feed_rise;
  logic lclk_rise;
  // Panel state
  logic bid_q;
  logic motor_sw_q;
  logic sup_q;
  logic stop_q;
  logic ss_pend_q;
  logic feed_alm_q;
  logic vfy_alm_q;
  // Arbitration
  logic [NSUP:0] req;
  logic [OW-1:0] owner_q;
  logic own_v_q;
  logic grant;
  logic [15:0] msg_num_q;
  // Sequencer
  tsc_seq_t seq_q;
  logic [2:0] hdr_idx_q;
  logic [10:0] feed_cnt_q;
  logic run_ok;
  logic hdr_go;
  logic do_step;
  logic man_step;
  logic [NSUP:0] step_q;
  // Transmitter
  tsc_cfg_t cfg_q;
  tsc_cfg_t cfg_eff;
  logic tx_go;
  logic tx_idle;
  logic [7:0] tx_char;
  logic [7:0] hdr_char;
  logic [7:0] src [0:NSUP];
  logic [15:0] tx_sr_q;
  logic [3:0] tx_cnt_q;
  logic ser_q;
  // Output flops
  tsc_lamp_t lamp_q;
  logic motor_q;
  logic [NSUP:0] online_q;
  logic [NSUP:0] prio_q;
  // APB
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic hit;

  // Next owner after the last, round robin
  function automatic logic [OW-1:0] pick(input logic [NSUP:0] r,
                                         input logic [OW-1:0] last);
    logic [OW-1:0] sel;
    int k;
    sel = last;
    for (int i = NSUP + 1; i >= 1; i--) begin
      k = (int'(last) + i) % (NSUP + 1);
      if (r[k]) begin
        sel = OW'(k);
      end
    end
    return sel;
  endfunction

  // Build one character frame, sent LSB first
  function automatic logic [15:0] frame(input logic [7:0] ch,
                                        input tsc_cfg_t c);
    logic [15:0] f;
    f = '1;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(c.levels)) begin
        if (c.sync) begin
          f[i] = ch[i];
        end else begin
          f[i+1] = ch[i];
        end
      end
    end
    // Start-stop: leading space, trailing mark
    if (!c.sync) begin
      f[0] = 1'b0;
    end
    return f;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_b_q <= 1'b0;
      rst_s_b_q <= 1'b0;
    end else begin
      rst_m_b_q <= 1'b1;
      rst_s_b_q <= rst_m_b_q;
    end
  end

  // All pins come from outside, two flops each
  assign pin_raw = {sw_in, tape_in, feed_in, link_clk, prio_in_b, read_bits,
                    verify_bits, header_char_select, supp_bid, supp_data};
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      pin_m_q <= PIN_IDLE;
      pin_s_q <= PIN_IDLE;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
    end
  end
  assign {sw_s, tape_s, feed_s, lclk_s, prio_s_b, rd_s, vf_s, hsel_s,
          sbid_s, sdata_s} = pin_s_q;

  // Edge history, only from the second stage
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      sw_p_q <= '0;
      feed_p_q <= 1'b0;
      lclk_p_q <= 1'b0;
    end else begin
      sw_p_q <= sw_s;
      feed_p_q <= feed_s;
      lclk_p_q <= lclk_s;
    end
  end
  assign press = sw_s & ~sw_p_q;
  assign rel = ~sw_s & sw_p_q;
  assign feed_rise = feed_s & ~feed_p_q;
  assign lclk_rise = lclk_s & ~lclk_p_q;

  // Operator settings; reset clears them all
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      bid_q <= 1'b0; // RULE25
      motor_sw_q <= 1'b0;
      sup_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      // Tape gone: request dropped, press refused
      if (!tape_s) begin
        bid_q <= 1'b0; // RULE1 RULE2 RULE14
      end else if (press.bid) begin
        bid_q <= ~bid_q; // RULE3
      end
      if (press.motor) begin
        motor_sw_q <= ~motor_sw_q; // RULE5
      end
      // Setting frozen while a request stands
      if (press.suppress && !bid_q) begin
        sup_q <= ~sup_q; // RULE6 RULE7
      end
      if (press.stop) begin
        stop_q <= ~stop_q; // RULE11 RULE12
      end
    end
  end

  // Step-send press held until the transmitter is free
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      ss_pend_q <= 1'b0;
    end else if (press.step_send && stop_q) begin
      ss_pend_q <= 1'b1;
    end else if (do_step || !stop_q) begin
      ss_pend_q <= 1'b0;
    end
  end

  // Alarms; a new fault wins over a clear press
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      feed_alm_q <= 1'b0;
      vfy_alm_q <= 1'b0;
    end else begin
      // Feed sense stayed quiet for the whole wait
      if (seq_q == SQ_FEED && feed_cnt_q == 11'h1 && !feed_rise) begin
        feed_alm_q <= 1'b1; // RULE15
      end else if (press.feed_clr && seq_q != SQ_FEED) begin
        feed_alm_q <= 1'b0; // RULE16
      end
      // Only the master has verifier contacts
      if (do_step && owner_q == '0 && rd_s != vf_s) begin
        vfy_alm_q <= 1'b1; // RULE17
      end else if (press.vfy_clr && rd_s == vf_s) begin
        vfy_alm_q <= 1'b0; // RULE18
      end
    end
  end

  // Requests: master first, then each supplementary
  assign req = {sbid_s, bid_q};
  assign grant = !own_v_q && (|req);

  // Arbiter: one owner until its request ends
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      owner_q <= '0;
      own_v_q <= 1'b0;
      msg_num_q <= '0;
    end else if (grant) begin
      owner_q <= pick(req, owner_q); // RULE19
      own_v_q <= 1'b1;
      // Suppressed count keeps the number
      if (!sup_q) begin
        msg_num_q <= msg_num_q + 16'h1; // RULE10
      end
    end else if (own_v_q && !req[owner_q]) begin
      own_v_q <= 1'b0; // RULE19
    end
  end

  // Auto stepping allowed only in this condition
  assign run_ok = own_v_q && !stop_q && !feed_alm_q && !vfy_alm_q
                  && (owner_q != '0 || tape_s); // RULE24
  assign hdr_go = seq_q == SQ_HDR && tx_idle;
  assign do_step = seq_q == SQ_RUN && tx_idle
                   && (run_ok || (stop_q && ss_pend_q)); // RULE13
  // Manual step moves the master tape without reading
  assign man_step = rel.step && tape_s && (!own_v_q || stop_q)
                    && seq_q != SQ_FEED; // RULE8

  // Message sequencer: header, then tape characters
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      seq_q <= SQ_IDLE;
      hdr_idx_q <= '0;
      feed_cnt_q <= '0;
    end else begin
      case (seq_q)
        // Wait for an owner
        SQ_IDLE: begin
          if (own_v_q) begin
            seq_q <= SQ_HDR;
            hdr_idx_q <= '0;
          end
        end
        // Header characters one by one
        SQ_HDR: begin
          if (!own_v_q) begin
            seq_q <= SQ_IDLE;
          end else if (hdr_go) begin
            if (hdr_idx_q == 3'(HDR_LEN - 1)) begin
              seq_q <= SQ_RUN;
            end
            hdr_idx_q <= hdr_idx_q + 3'h1;
          end
        end
        // Stepping; master steps are feed checked
        SQ_RUN: begin
          if (!own_v_q) begin
            seq_q <= SQ_IDLE;
          end else if (do_step && owner_q == '0) begin
            seq_q <= SQ_FEED;
            feed_cnt_q <= 11'(FEED_WAIT_CYC);
          end
        end
        // Wait for the feed contact
        SQ_FEED: begin
          if (feed_rise || feed_cnt_q == 11'h1) begin
            seq_q <= SQ_RUN;
          end else begin
            feed_cnt_q <= feed_cnt_q - 11'h1;
          end
        end
        default: begin
          seq_q <= SQ_IDLE;
        end
      endcase
    end
  end

  // Reader step pulses, one clock wide
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      step_q <= '0;
    end else begin
      step_q <= '0;
      if (do_step) begin
        step_q[owner_q] <= 1'b1; // RULE10 RULE24
      end
      if (man_step) begin
        step_q[0] <= 1'b1; // RULE8
      end
    end
  end

  // Character sources by reader index
  always_comb begin
    src[0] = rd_s;
    for (int k = 1; k <= NSUP; k++) begin
      src[k] = sdata_s[8*(k-1) +: 8]; // RULE22
    end
  end

  // Last header character from the panel switches
  assign hdr_char = (hdr_idx_q == 3'(HDR_LEN - 1)) ? hsel_s
                    : HDR_FIXED[hdr_idx_q]; // RULE20
  assign tx_char = hdr_go ? hdr_char : src[owner_q];
  assign tx_go = hdr_go || do_step;

  // Supplementary traffic is always eight-level
  always_comb begin
    cfg_eff = cfg_q;
    if (owner_q != '0) begin
      cfg_eff.levels = LEV_SUP; // RULE22
    end
  end

  assign tx_idle = (tx_cnt_q == 4'h0);

  // Serial shifter, one unit per link clock rise
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      tx_sr_q <= '1;
      tx_cnt_q <= '0;
      ser_q <= 1'b1;
    end else if (tx_go) begin
      tx_sr_q <= frame(tx_char, cfg_eff); // RULE21
      tx_cnt_q <= cfg_eff.units;
    end else if (lclk_rise) begin
      // No link clock, no transmission; line idles mark
      ser_q <= tx_idle ? 1'b1 : tx_sr_q[0]; // RULE9
      if (!tx_idle) begin
        tx_sr_q <= {1'b1, tx_sr_q[15:1]};
        tx_cnt_q <= tx_cnt_q - 4'h1;
      end
    end
  end

  // Indicators and motor drive
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      lamp_q <= '0;
      motor_q <= 1'b0;
      online_q <= '0;
      prio_q <= '0;
    end else begin
      lamp_q.bid <= bid_q;
      lamp_q.online <= own_v_q && owner_q == '0;
      lamp_q.motor <= motor_sw_q || bid_q; // RULE4 RULE5
      lamp_q.suppress <= sup_q;
      lamp_q.stop <= stop_q;
      lamp_q.feed <= feed_alm_q;
      lamp_q.vfy <= vfy_alm_q;
      lamp_q.prio <= !prio_s_b; // RULE23
      motor_q <= motor_sw_q || bid_q; // RULE4
      online_q <= '0;
      online_q[owner_q] <= own_v_q; // RULE10
      // Negative line level lights every sender
      prio_q <= {(NSUP + 1){!prio_s_b}}; // RULE23
    end
  end

  // APB decode; misaligned or unknown offsets miss
  assign hit = paddr == ADDR_CFG || paddr == ADDR_STAT
               || paddr == ADDR_MSG;
  always_comb begin
    rd_mux = '0;
    case (paddr)
      ADDR_CFG: rd_mux[8:0] = cfg_q;
      ADDR_STAT: rd_mux[16:0] = {owner_q[2:0], own_v_q, seq_q, ss_pend_q,
                                 feed_alm_q, vfy_alm_q, stop_q, sup_q,
                                 motor_sw_q, bid_q, tape_s, online_q[0],
                                 lamp_q.prio, tx_idle};
      ADDR_MSG: rd_mux[15:0] = msg_num_q;
      default: rd_mux = '0;
    endcase
  end

  // Register writes land at the access edge only
  always_ff @(posedge clk or negedge rst_s_b_q) begin
    if (!rst_s_b_q) begin
      cfg_q <= CFG_RST;
      prdata_q <= '0;
    end else begin
      if (psel && penable && pwrite && paddr == ADDR_CFG) begin
        cfg_q <= pwdata[8:0];
      end
      // Read data captured in setup, held for access
      if (psel && !penable) begin
        prdata_q <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // Outputs
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;
  assign lamp = lamp_q;
  assign motor_on = motor_q;
  assign alarm_contact = lamp_q.feed; // RULE15
  assign reader_step = step_q;
  assign online = online_q;
  assign prio_lamp = prio_q;
  assign serial_out = ser_q;

  // Checks run on the core clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s_b_q);

  // Step then silent feed contact for the full wait
  sequence feed_miss;
    seq_q == SQ_FEED && feed_cnt_q == 11'h1 && !feed_rise;
  endsequence
  // Master step with disagreeing contacts
  sequence mism_step;
    do_step && owner_q == '0 && rd_s != vf_s;
  endsequence

  bid_refuse_a: assert property (press.bid && !tape_s |=> !bid_q) // RULE1
    else $error("request set without tape");
  bid_drop_a: assert property ($fell(tape_s) |=> !bid_q) // RULE2
    else $error("request kept after tape removal");
  bid_toggle_a: assert property (tape_s && press.bid |=> bid_q != $past(bid_q)) // RULE3
    else $error("request did not toggle");
  motor_follow_a: assert property ($rose(bid_q) |=> motor_on && lamp.motor) // RULE4
    else $error("motors did not follow request");
  sup_hold_a: assert property (bid_q && press.suppress |=> $stable(sup_q)) // RULE7
    else $error("suppression changed during request");
  stop_halt_a: assert property ((stop_q && !ss_pend_q && !man_step) [*2] |=> step_q == '0) // RULE11
    else $error("reader stepped while stopped");
  feed_alarm_a: assert property (feed_miss |=> feed_alm_q ##1 alarm_contact) // RULE15
    else $error("feed fault not raised");
  vfy_alarm_a: assert property (mism_step |=> vfy_alm_q ##1 lamp.vfy) // RULE17
    else $error("verify mismatch not raised");
  one_reader_a: assert property ($onehot0(online)) // RULE19
    else $error("more than one reader on line");
  prio_lamp_a: assert property (!prio_s_b |=> &prio_lamp ##0 lamp.prio) // RULE23
    else $error("priority lamps not lit");
  start_bit_a: assert property (tx_go && !cfg_eff.sync |=> !tx_sr_q[0]) // RULE21
    else $error("start-stop frame lacks start unit");
endmodule

//--- tsc_pkg.sv
// Constants and types for the tape sender control sequencer
// How it works
// RULE1: No tape: request press is refused
// RULE2: Tape removal clears the send request
// RULE3: Request switch toggles the send request
// RULE4: Motors follow request when motor switch off
// RULE5: Motor switch lights lamp, starts motors
// RULE6: Idle: suppression switch toggles the setting
// RULE7: Requesting: suppression switch is ignored
// RULE8: Step release advances one unread character
// RULE9: Outside link clock paces all transmission
// RULE10: Grant: on-line, reader runs, number advances
// RULE11: Stop press halts stepping, lights lamp
// RULE12: Second stop press resumes stepping
// RULE13: Stopped: step-send steps and transmits
// RULE14: Reader stops after tape end passes
// RULE15: No feed after step raises feed alarm
// RULE16: Feed switch clears alarm outside the feed wait
// RULE17: Read and verify mismatch raises alarm
// RULE18: Verify switch clears alarm once matching
// RULE19: One reader at a time, taking turns
// RULE20: Header ends with the operator's character
// RULE21: Sync and start-stop framing, up to eight levels
// RULE22: Supplementary inputs send eight-level characters
// RULE23: Priority input level drives all lamps
// RULE24: Step only on-line, running, tape, no alarm; a step-send press while stopped steps even with an alarm set
// RULE25: Reset clears all control state
package tsc_pkg;
  // Core clock rate
  localparam int CLK_MHZ = 50;
  // Longest wait for feed sense after a step
  localparam int FEED_WAIT_US = 20;
  localparam int FEED_WAIT_CYC = FEED_WAIT_US * CLK_MHZ;
  // APB byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MSG = 8'h08;
  // Header length and its fixed leading characters
  localparam int HDR_LEN = 8;
  localparam logic [7:0] HDR_FIXED [0:HDR_LEN-2] = '{
    8'h01, 8'h01, 8'h0d, 8'h0a, 8'h5a, 8'h43, 8'h5a};
  // Code level count forced for supplementary input
  localparam logic [3:0] LEV_SUP = 4'h8;
  // Operator switches, one bit each
  typedef struct packed {
    logic bid;
    logic motor;
    logic suppress;
    logic stop;
    logic step;
    logic step_send;
    logic feed_clr;
    logic vfy_clr;
  } tsc_sw_t;
  // Panel indicators
  typedef struct packed {
    logic bid;
    logic online;
    logic motor;
    logic suppress;
    logic stop;
    logic feed;
    logic vfy;
    logic prio;
  } tsc_lamp_t;
  // Framing setup
  typedef struct packed {
    logic sync;
    logic [3:0] units;
    logic [3:0] levels;
  } tsc_cfg_t;
  // Framing after reset: start-stop, 10 units, 8 levels
  localparam tsc_cfg_t CFG_RST = '{sync: 1'b0, units: 4'ha, levels: 4'h8};
  // Sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_HDR, SQ_RUN, SQ_FEED} tsc_seq_t;
endpackage

//--- tsc_line_mon.sv
// Far-side model: external link clock source and start-stop line monitor
module tsc_line_mon (
  // Bench control
  input wire logic run,
  // Link side
  output logic link_clk,
  input wire logic line,
  // Received characters
  output logic [15:0] rx_cnt,
  output logic [7:0] rx_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pos; // 0 idle, 1..8 data, 9 stop
  logic [7:0] sh; // Data shifted in LSB first
  // 80 ns pulses every 160 ns only while the bench runs the link, low otherwise
  initial begin
    link_clk = 1'b0;
    forever begin
      #80;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end
  // Receiver state at start
  initial begin
    pos = 4'h0;
    sh = 8'h00;
    rx_cnt = 16'h0000;
    rx_last = 8'h00;
  end
  // Sampled a full period after launch, so the unit has long settled
  always @(posedge link_clk) begin
    if (pos == 4'h0) begin
      if (line === 1'b0) pos = 4'h1; // Start unit seen
    end else if (pos < 4'h9) begin
      sh = {line, sh[7:1]};
      pos = pos + 4'h1;
    end else begin
      // Only a clean stop unit counts as a character
      if (line === 1'b1) begin
        rx_cnt = rx_cnt + 16'h0001;
        rx_last = sh;
      end
      pos = 4'h0;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the tape sender control sequencer
module tb_top import tsc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  // Switch bit positions inside the switch struct
  localparam int SBID = 7, SMOT = 6, SSUP = 5, SSTP = 4, SSTEP = 3, SSND = 2, SFCL = 1, SVCL = 0;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, read_bits, verify_bits, hdr_sel, rx_last;
  logic [31:0] pwdata, prdata, q, supp_data;
  tsc_sw_t sw;
  tsc_lamp_t lamp;
  logic tape_in, feed_in, feed_ok, motor_on, alarm_contact, link_clk, prio_in_b, serial_out, run;
  logic [3:0] supp_bid;
  logic [4:0] reader_step, online, prio_lamp, o;
  logic [15:0] rx_cnt, r, s, m;
  logic [15:0] step_cnt = '0;
  int miscompares, num_checks;

  tsc_top #(.NSUP(4)) dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sw_in(sw),
    .header_char_select(hdr_sel), .lamp(lamp), .tape_in(tape_in), .feed_in(feed_in), .read_bits(read_bits),
    .verify_bits(verify_bits), .motor_on(motor_on), .alarm_contact(alarm_contact), .supp_bid(supp_bid),
    .supp_data(supp_data), .reader_step(reader_step), .online(online), .prio_lamp(prio_lamp),
    .link_clk(link_clk), .prio_in_b(prio_in_b), .serial_out(serial_out));

  tsc_line_mon mon_u (.run(run), .link_clk(link_clk), .line(serial_out), .rx_cnt(rx_cnt), .rx_last(rx_last));

  // 50 MHz core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Reader model: feed contact follows each master step unless tape held back
  always @(posedge clk) begin
    feed_in <= reader_step[0] === 1'b1 && feed_ok;
    if (reader_step[0] === 1'b1) step_cnt <= step_cnt + 16'h0001;
  end

  // Compare and count
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
    num_checks++;
    if (g !== ex) begin
      $display("wrong value %s expected %h seen %h", n, ex, g);
      miscompares++;
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Press and release one panel switch, then let lamps settle
  task automatic press(input int b);
    sw[b] <= 1'b1;
    repeat (6) @(posedge clk);
    sw[b] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Bounded wait for the monitor to reach a character count
  task automatic wait_rx(input logic [15:0] n);
    for (int k = 0; k < 9000 && rx_cnt < n; k++) @(posedge clk);
  endtask

  task automatic final_report;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    final_report;
  end

  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sw = '0;
    {tape_in, run, supp_bid} = '0;
    {feed_ok, prio_in_b} = 2'b11;
    read_bits = 8'h35;
    verify_bits = 8'h35;
    hdr_sel = 8'h4e;
    supp_data = {4{8'h5c}};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    // Power-up state and register port
    chk("lamps", 8'h00, lamp);
    chk("motor", 0, motor_on);
    chk("line idle", 1, serial_out);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk("cfg reset", 32'h0a8, q);
    apb(1'b1, ADDR_CFG, 32'hfffffe5b);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk("cfg rw", 32'h05b, q);
    apb(1'b1, ADDR_CFG, 32'h0a8);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    // Priority line drives every lamp
    prio_in_b <= 1'b0;
    repeat (8) @(posedge clk);
    chk("prio lamps", 5'h1f, prio_lamp);
    chk("prio lamp", 1, lamp.prio);
    prio_in_b <= 1'b1;
    repeat (8) @(posedge clk);
    chk("prio off", 5'h00, prio_lamp);
    // Motor switch on then off
    press(SMOT);
    chk("motor lamp", 1, lamp.motor);
    chk("motor on", 1, motor_on);
    press(SMOT);
    chk("motor off", 0, motor_on);
    // Request refused without tape
    press(SBID);
    chk("no tape bid", 0, lamp.bid);
    press(SSUP);
    chk("suppress on", 1, lamp.suppress);
    press(SSUP);
    chk("suppress off", 0, lamp.suppress);
    // Idle step: one position, nothing sent
    tape_in <= 1'b1;
    s = step_cnt;
    r = rx_cnt;
    press(SSTEP);
    chk("step count", s + 16'h1, step_cnt);
    chk("step no send", r, rx_cnt);
    // Grant, motors follow, number advances, suppress ignored
    apb(1'b0, ADDR_MSG, 32'h0);
    m = q[15:0];
    press(SBID);
    chk("bid lamp", 1, lamp.bid);
    chk("motor follows", 1, motor_on);
    chk("online lamp", 1, lamp.online);
    apb(1'b0, ADDR_MSG, 32'h0);
    chk("msg number", m + 16'h1, q[15:0]);
    press(SSUP);
    chk("suppress held", 0, lamp.suppress);
    press(SBID);
    chk("bid toggled", 0, lamp.bid);
    chk("motor off", 0, motor_on);
    press(SBID);
    tape_in <= 1'b0;
    repeat (8) @(posedge clk);
    chk("tape out bid", 0, lamp.bid);
    chk("tape out online", 0, online);
    // Link clock on; a frame loaded while it stood still drains first
    run <= 1'b1;
    repeat (200) @(posedge clk);
    tape_in <= 1'b1;
    r = rx_cnt;
    press(SBID);
    wait_rx(r + 16'h8);
    chk("header last", 8'h4e, rx_last);
    wait_rx(r + 16'h9);
    chk("tape char", 8'h35, rx_last);
    press(SSTP);
    chk("stop lamp", 1, lamp.stop);
    repeat (1500) @(posedge clk);
    s = step_cnt;
    repeat (3000) @(posedge clk);
    chk("stopped", s, step_cnt);
    r = rx_cnt;
    press(SSND);
    wait_rx(r + 16'h1);
    chk("step send", s + 16'h1, step_cnt);
    chk("step send char", 8'h35, rx_last);
    // Five-level start-stop frame pads the data units with marks
    apb(1'b1, ADDR_CFG, 32'h0a5);
    r = rx_cnt;
    press(SSND);
    wait_rx(r + 16'h1);
    chk("five level char", 8'hf5, rx_last);
    apb(1'b1, ADDR_CFG, 32'h0a8);
    press(SSTP);
    chk("stop cleared", 0, lamp.stop);
    repeat (3000) @(posedge clk);
    chk("resumed", 1, step_cnt > s + 16'h1);
    // Feed alarm and its clearing
    feed_ok <= 1'b0;
    for (int k = 0; k < 4000 && alarm_contact !== 1'b1; k++) @(posedge clk);
    chk("feed lamp", 1, lamp.feed);
    chk("alarm contact", 1, alarm_contact);
    s = step_cnt;
    repeat (2000) @(posedge clk);
    chk("halted in alarm", s, step_cnt);
    feed_ok <= 1'b1;
    press(SFCL);
    chk("feed cleared", 0, lamp.feed);
    chk("contact normal", 0, alarm_contact);
    // Readback mismatch alarm
    read_bits <= 8'h34;
    for (int k = 0; k < 4000 && lamp.vfy !== 1'b1; k++) @(posedge clk);
    chk("verify lamp", 1, lamp.vfy);
    read_bits <= 8'h35;
    press(SVCL);
    chk("verify cleared", 0, lamp.vfy);
    // End of tape stops the reader
    tape_in <= 1'b0;
    repeat (10) @(posedge clk);
    s = step_cnt;
    repeat (2000) @(posedge clk);
    chk("end of tape", s, step_cnt);
    // Supplementary requesters take turns
    r = rx_cnt;
    supp_bid <= 4'b0011;
    repeat (30) @(posedge clk);
    o = online;
    chk("one owner", 1, o == 5'b00010 || o == 5'b00100);
    wait_rx(r + 16'h9);
    chk("supp char", 8'h5c, rx_last);
    supp_bid <= supp_bid & ~o[4:1];
    repeat (30) @(posedge clk);
    chk("next owner", o[1] ? 5'b00100 : 5'b00010, online);
    supp_bid <= 4'b0000;
    run <= 1'b0;
    repeat (20) @(posedge clk);
    final_report;
  end
endmodule
